// file: hdl/rot_unit_params.svh
`ifndef ROT_UNIT_PARAMS_SVH
`define ROT_UNIT_PARAMS_SVH

// Register byte offsets (low twelve address bits)
`define OFF_INSN 12'h000
`define OFF_STATUS 12'h004
`define OFF_ACC 12'h008
`define OFF_GPR 12'h00c
`define OFF_PTR 12'h010
`define OFF_INDEX 12'h014
`define MEM_SEL 2'h1
`define HSIZE_WORD 3'h2

// Status fields
`define STAT_BUSY 0
`define STAT_BAD 1
`define STAT_LASTM_LSB 4
`define STAT_LASTT_LSB 8

// Flag bit positions
`define FLAG_S 7
`define FLAG_Z 6
`define FLAG_H 4
`define FLAG_PV 2
`define FLAG_N 1
`define FLAG_C 0

// Register file slots
`define SLOT_H 3'h4
`define SLOT_L 3'h5
`define SLOT_A 3'h7

// Opcode bytes
`define OP_ACC_ROTATE_LEFT_CIRCULAR 8'h07
`define OP_RLA 8'h17
`define OP_ACC_ROTATE_RIGHT_CIRCULAR 8'h0f
`define OP_RRA 8'h1f
`define PFX_CB 8'hcb
`define PFX_X 8'hdd
`define PFX_Y 8'hfd
`define OP_DEC_IDX 8'h2b
`define OP_RLC_MEM 8'h06
`define RLC_REG_TOP 5'h00

// Clock states per machine cycle, one state per hclk cycle
`define TS_OPCODE 3'h4
`define TS_DEC_INT 3'h6
`define TS_MEM_RD 3'h4
`define TS_MEM_WR 3'h3
`define TS_DISP 3'h3
`define TS_ADDR_CALC 3'h5

// Machine cycles per instruction
`define MC_ACC 3'h1
`define MC_REG 3'h2
`define MC_HL 3'h4
`define MC_IDX 3'h6
`define MC_DEC 3'h2

// Reset values
`define RST_CORE '0

`endif

// file: hdl/rot_unit_pkg.sv
package rot_unit_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_OPC = 2'h1,
        ST_MRD = 2'h3,
        ST_MWR = 2'h2
    } state_t;

    typedef enum logic [3:0] {
        K_NONE = 4'h0,
        K_ACC_ROTATE_LEFT_CIRCULAR = 4'h1,
        K_RLA = 4'h2,
        K_ACC_ROTATE_RIGHT_CIRCULAR = 4'h3,
        K_RRA = 4'h4,
        K_RLC_REG = 4'h5,
        K_RLC_HL = 4'h6,
        K_RLC_IDX = 4'h7,
        K_DEC_X = 4'h8,
        K_DEC_Y = 4'h9
    } kind_t;

    typedef enum logic [1:0] {
        ROT_LC = 2'h0,
        ROT_LT = 2'h1,
        ROT_RC = 2'h2,
        ROT_RT = 2'h3
    } rot_t;

endpackage

// file: hdl/rot_flag_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "rot_unit_params.svh"
module rot_flag_unit (
    input wire rot_unit_pkg::rot_t op,
    input wire logic full,
    input wire logic [7:0] operand,
    input wire logic [7:0] flags_in,
    output logic [7:0] result,
    output logic [7:0] flags_out
);
    always_comb
    begin
        case (op)
            rot_unit_pkg::ROT_LC: result = {operand[6:0], operand[7]};
            rot_unit_pkg::ROT_LT: result = {operand[6:0], flags_in[`FLAG_C]};
            rot_unit_pkg::ROT_RC: result = {operand[0], operand[7:1]};
            default: result = {flags_in[`FLAG_C], operand[7:1]};
        endcase
        flags_out = flags_in;
        flags_out[`FLAG_H] = 1'b0;
        flags_out[`FLAG_N] = 1'b0;
        if (op == rot_unit_pkg::ROT_LC || op == rot_unit_pkg::ROT_LT)
        begin
            flags_out[`FLAG_C] = operand[7];
        end
        else
        begin
            flags_out[`FLAG_C] = operand[0];
        end
        // Accumulator forms keep sign, zero and parity untouched
        if (full)
        begin
            flags_out[`FLAG_S] = result[7];
            flags_out[`FLAG_Z] = (result == 8'h00);
            flags_out[`FLAG_PV] = ~^result;
        end
    end
endmodule
`default_nettype wire

// file: hdl/rotate_unit_and_index_decrement.sv
// Notes on behaviour
// [RULE1] Bytes FD 2B decrement index_reg_y by one as sixteen bits.
// [RULE2] Each index decrement lasts two machine cycles, ten states: four then six.
// [RULE3] Index decrements leave every flag untouched.
// [RULE4] Opcode 07 rotates the accumulator left; bit 7 to carry and bit 0.
// [RULE5] Left rotate through carry: old carry to bit 0, bit 7 to carry.
// [RULE6] Left rotate through carry is opcode 17.
// [RULE7] Opcode 0F rotates right; bit 0 to carry and bit 7.
// [RULE8] Opcode 1F rotates right through carry; old carry to bit 7.
// [RULE9] Accumulator rotates clear H and N, keep S, Z and parity.
// [RULE10] Register operand field: B 000 through L 101, A 111.
// [RULE11] Register form is CB then 00000 and the three-bit field.
// [RULE12] Prefixed rotates set S, Z, even parity; clear H, N; carry from bit 7.
// [RULE13] CB 06 rotates the byte at address_pointer_pair and writes it back.
// [RULE14] DD CB d 06 rotates the byte at index_reg_x plus signed d.
// [RULE15] Indexed memory rotate lasts six machine cycles, 23 states.
// [RULE16] Memory forms read, rotate and write back before the next instruction.
`timescale 1ns/1ps
`default_nettype none
`include "rot_unit_params.svh"
module rotate_unit_and_index_decrement (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    typedef struct packed {
        rot_unit_pkg::state_t st;
        rot_unit_pkg::kind_t kind;
        logic [31:0] insn;
        logic [2:0] m;
        logic [2:0] t;
        logic [4:0] tot;
        logic [2:0] last_m;
        logic [4:0] last_tot;
        logic bad;
        logic [7:0][7:0] gpr;
        logic [7:0] flg;
        logic [15:0] ix;
        logic [15:0] iy;
        logic [15:0] ea;
        logic [7:0] opnd;
        logic [255:0][7:0] mem;
        logic dp_valid;
        logic dp_write;
        logic dp_hit;
        logic [11:0] dp_addr;
        logic [31:0] rdata;
    } core_t;

    core_t q;
    core_t n;
    logic start;
    logic mend;
    logic commit;
    rot_unit_pkg::rot_t rop;
    logic rfull;
    logic [7:0] ropnd;
    logic [7:0] rres;
    logic [7:0] rflg;
    logic [7:0] mem_rd_byte;

    function automatic rot_unit_pkg::kind_t decode(input logic [31:0] w);
        rot_unit_pkg::kind_t k;
        k = rot_unit_pkg::K_NONE;
        if (w[7:0] == `OP_ACC_ROTATE_LEFT_CIRCULAR)
            k = rot_unit_pkg::K_ACC_ROTATE_LEFT_CIRCULAR; // see [RULE4]
        else if (w[7:0] == `OP_RLA)
            k = rot_unit_pkg::K_RLA; // see [RULE6]
        else if (w[7:0] == `OP_ACC_ROTATE_RIGHT_CIRCULAR)
            k = rot_unit_pkg::K_ACC_ROTATE_RIGHT_CIRCULAR; // see [RULE7]
        else if (w[7:0] == `OP_RRA)
            k = rot_unit_pkg::K_RRA; // see [RULE8]
        else if (w[7:0] == `PFX_CB && w[15:8] == `OP_RLC_MEM)
            k = rot_unit_pkg::K_RLC_HL; // see [RULE13]
        else if (w[7:0] == `PFX_CB && w[15:11] == `RLC_REG_TOP)
            k = rot_unit_pkg::K_RLC_REG; // see [RULE11]
        else if (w[7:0] == `PFX_X && w[15:8] == `PFX_CB && w[31:24] == `OP_RLC_MEM)
            k = rot_unit_pkg::K_RLC_IDX; // see [RULE14]
        else if (w[7:0] == `PFX_X && w[15:8] == `OP_DEC_IDX)
            k = rot_unit_pkg::K_DEC_X;
        else if (w[7:0] == `PFX_Y && w[15:8] == `OP_DEC_IDX)
            k = rot_unit_pkg::K_DEC_Y; // see [RULE1]
        return k;
    endfunction

    function automatic logic [2:0] mcount(input rot_unit_pkg::kind_t k);
        case (k)
            rot_unit_pkg::K_RLC_REG: return `MC_REG;
            rot_unit_pkg::K_RLC_HL: return `MC_HL;
            rot_unit_pkg::K_RLC_IDX: return `MC_IDX; // see [RULE15]
            rot_unit_pkg::K_DEC_X, rot_unit_pkg::K_DEC_Y: return `MC_DEC; // see [RULE2]
            default: return `MC_ACC;
        endcase
    endfunction

    function automatic logic [2:0] mlen(input rot_unit_pkg::kind_t k, input logic [2:0] m);
        logic [2:0] len;
        len = `TS_OPCODE;
        case (k)
            rot_unit_pkg::K_RLC_HL:
            begin
                if (m == 3'h2)
                    len = `TS_MEM_RD;
                else if (m == 3'h3)
                    len = `TS_MEM_WR;
            end
            rot_unit_pkg::K_RLC_IDX:
            begin
                // Opcode, opcode, displacement, address add, read, write
                if (m == 3'h2)
                    len = `TS_DISP; // see [RULE15]
                else if (m == 3'h3)
                    len = `TS_ADDR_CALC;
                else if (m == 3'h4)
                    len = `TS_MEM_RD;
                else if (m == 3'h5)
                    len = `TS_MEM_WR;
            end
            rot_unit_pkg::K_DEC_X, rot_unit_pkg::K_DEC_Y:
            begin
                if (m == 3'h1)
                    len = `TS_DEC_INT; // see [RULE2]
            end
            default: len = `TS_OPCODE;
        endcase
        return len;
    endfunction

    function automatic rot_unit_pkg::state_t phase(input rot_unit_pkg::kind_t k, input logic [2:0] m);
        logic memk;
        memk = (k == rot_unit_pkg::K_RLC_HL) || (k == rot_unit_pkg::K_RLC_IDX);
        if (memk && m == mcount(k) - 3'h2)
            return rot_unit_pkg::ST_MRD;
        else if (memk && m == mcount(k) - 3'h1)
            return rot_unit_pkg::ST_MWR;
        return rot_unit_pkg::ST_OPC;
    endfunction

    function automatic logic [31:0] read_word(input core_t s, input logic [11:0] a);
        logic [31:0] w;
        w = 32'h0;
        if (a[11:10] == `MEM_SEL)
            w = {24'h0, s.mem[a[9:2]]};
        else if (a == `OFF_INSN)
            w = s.insn;
        else if (a == `OFF_STATUS)
        begin
            w[`STAT_BUSY] = (s.st != rot_unit_pkg::ST_IDLE);
            w[`STAT_BAD] = s.bad;
            w[`STAT_LASTM_LSB +: 3] = s.last_m;
            w[`STAT_LASTT_LSB +: 5] = s.last_tot;
        end
        else if (a == `OFF_ACC)
            w = {16'h0, s.flg, s.gpr[`SLOT_A]};
        else if (a == `OFF_GPR)
            w = {s.gpr[0], s.gpr[1], s.gpr[2], s.gpr[3]};
        else if (a == `OFF_PTR)
            w = {16'h0, s.gpr[`SLOT_H], s.gpr[`SLOT_L]};
        else if (a == `OFF_INDEX)
            w = {s.iy, s.ix};
        return w;
    endfunction

    // One shared rotator; operand and mode follow the running instruction
    always_comb
    begin
        rfull = 1'b1;
        ropnd = q.opnd;
        case (q.kind)
            rot_unit_pkg::K_RLA: rop = rot_unit_pkg::ROT_LT; // see [RULE5]
            rot_unit_pkg::K_ACC_ROTATE_RIGHT_CIRCULAR: rop = rot_unit_pkg::ROT_RC; // see [RULE7]
            rot_unit_pkg::K_RRA: rop = rot_unit_pkg::ROT_RT; // see [RULE8]
            default: rop = rot_unit_pkg::ROT_LC; // see [RULE4]
        endcase
        if (q.kind == rot_unit_pkg::K_ACC_ROTATE_LEFT_CIRCULAR || q.kind == rot_unit_pkg::K_RLA ||
            q.kind == rot_unit_pkg::K_ACC_ROTATE_RIGHT_CIRCULAR || q.kind == rot_unit_pkg::K_RRA)
        begin
            rfull = 1'b0; // see [RULE9]
            ropnd = q.gpr[`SLOT_A];
        end
        else if (q.kind == rot_unit_pkg::K_RLC_REG)
        begin
            ropnd = q.gpr[q.insn[10:8]]; // see [RULE10]
        end
    end

    rot_flag_unit u_rot (
        .op(rop),
        .full(rfull),
        .operand(ropnd),
        .flags_in(q.flg),
        .result(rres),
        .flags_out(rflg)
    );

    assign mem_rd_byte = q.mem[q.ea[7:0]];

    always_comb
    begin
        n = q;
        start = 1'b0;
        mend = 1'b0;
        commit = 1'b0;
        n.dp_valid = hsel && htrans[1] && hready && (hsize == `HSIZE_WORD);
        n.dp_write = hwrite;
        n.dp_hit = (haddr[31:12] == 20'h0);
        n.dp_addr = haddr[11:0];
        // Writes while an instruction runs are dropped so state cannot tear
        if (q.dp_valid && q.dp_write && q.dp_hit && q.st == rot_unit_pkg::ST_IDLE)
        begin
            if (q.dp_addr[11:10] == `MEM_SEL)
                n.mem[q.dp_addr[9:2]] = hwdata[7:0];
            else if (q.dp_addr == `OFF_INSN)
            begin
                n.insn = hwdata;
                n.kind = decode(hwdata);
                n.bad = (n.kind == rot_unit_pkg::K_NONE);
                if (!n.bad)
                begin
                    start = 1'b1;
                    n.st = rot_unit_pkg::ST_OPC;
                    n.m = 3'h0;
                    n.t = 3'h0;
                    n.tot = 5'h0;
                end
                if (n.kind == rot_unit_pkg::K_RLC_HL)
                    n.ea = {q.gpr[`SLOT_H], q.gpr[`SLOT_L]}; // see [RULE13]
                else
                    n.ea = q.ix + {{8{hwdata[23]}}, hwdata[23:16]}; // see [RULE14]
            end
            else if (q.dp_addr == `OFF_ACC)
            begin
                n.gpr[`SLOT_A] = hwdata[7:0];
                n.flg = hwdata[15:8];
            end
            else if (q.dp_addr == `OFF_GPR)
            begin
                n.gpr[0] = hwdata[31:24];
                n.gpr[1] = hwdata[23:16];
                n.gpr[2] = hwdata[15:8];
                n.gpr[3] = hwdata[7:0];
            end
            else if (q.dp_addr == `OFF_PTR)
            begin
                n.gpr[`SLOT_H] = hwdata[15:8];
                n.gpr[`SLOT_L] = hwdata[7:0];
            end
            else if (q.dp_addr == `OFF_INDEX)
            begin
                n.iy = hwdata[31:16];
                n.ix = hwdata[15:0];
            end
        end
        if (q.st != rot_unit_pkg::ST_IDLE)
        begin
            n.t = q.t + 3'h1;
            n.tot = q.tot + 5'h1;
            if (n.t == mlen(q.kind, q.m))
            begin
                mend = 1'b1;
                n.t = 3'h0;
                n.m = q.m + 3'h1;
                if (q.st == rot_unit_pkg::ST_MRD)
                    n.opnd = mem_rd_byte; // see [RULE16]
                if (n.m == mcount(q.kind))
                begin
                    commit = 1'b1;
                    n.st = rot_unit_pkg::ST_IDLE;
                    n.last_m = n.m;
                    n.last_tot = n.tot;
                    case (q.kind)
                        rot_unit_pkg::K_DEC_X: n.ix = q.ix - 16'h1; // see [RULE3]
                        rot_unit_pkg::K_DEC_Y: n.iy = q.iy - 16'h1; // see [RULE1]
                        rot_unit_pkg::K_RLC_REG:
                        begin
                            n.gpr[q.insn[10:8]] = rres; // see [RULE10]
                            n.flg = rflg; // see [RULE12]
                        end
                        rot_unit_pkg::K_RLC_HL, rot_unit_pkg::K_RLC_IDX:
                        begin
                            n.mem[q.ea[7:0]] = rres; // see [RULE16]
                            n.flg = rflg;
                        end
                        default:
                        begin
                            n.gpr[`SLOT_A] = rres; // see [RULE9]
                            n.flg = rflg;
                        end
                    endcase
                end
                else
                begin
                    n.st = phase(q.kind, n.m);
                end
            end
        end
        // Read data is taken from the next state, so a write just before reads back
        if (n.dp_valid && !hwrite)
            n.rdata = n.dp_hit ? read_word(n, haddr[11:0]) : 32'h0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            q <= `RST_CORE;
        else
            q <= n;
    end

    // Zero wait states: every transfer completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;

    chk_dec_y_value: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE1]
        commit && q.kind == rot_unit_pkg::K_DEC_Y |=> q.iy == $past(q.iy) - 16'h1)
        else $error("index_reg_y decrement wrong");

    chk_dec_cycle_count: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE2]
        commit && (q.kind == rot_unit_pkg::K_DEC_X || q.kind == rot_unit_pkg::K_DEC_Y)
        |-> q.tot == 5'h9 && q.m == 3'h1 && q.t == 3'h5)
        else $error("index decrement not ten states");

    chk_dec_flags_kept: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE3]
        commit && (q.kind == rot_unit_pkg::K_DEC_X || q.kind == rot_unit_pkg::K_DEC_Y)
        |=> $stable(q.flg))
        else $error("index decrement touched flags");

    chk_acc_left_circ: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE4]
        commit && q.kind == rot_unit_pkg::K_ACC_ROTATE_LEFT_CIRCULAR
        |=> q.gpr[`SLOT_A] == {$past(q.gpr[`SLOT_A][6:0]), $past(q.gpr[`SLOT_A][7])}
        && q.flg[`FLAG_C] == $past(q.gpr[`SLOT_A][7]))
        else $error("accumulator left circular rotate wrong");

    chk_acc_left_thru: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE5]
        commit && q.kind == rot_unit_pkg::K_RLA
        |=> q.gpr[`SLOT_A] == {$past(q.gpr[`SLOT_A][6:0]), $past(q.flg[`FLAG_C])}
        && q.flg[`FLAG_C] == $past(q.gpr[`SLOT_A][7]))
        else $error("accumulator left rotate through carry wrong");

    chk_rla_decode: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE6]
        start && hwdata[7:0] == `OP_RLA |=> q.kind == rot_unit_pkg::K_RLA ##1 q.st != rot_unit_pkg::ST_IDLE)
        else $error("opcode 17 not taken as left rotate through carry");

    chk_acc_right_circ: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE7]
        commit && q.kind == rot_unit_pkg::K_ACC_ROTATE_RIGHT_CIRCULAR
        |=> q.gpr[`SLOT_A] == {$past(q.gpr[`SLOT_A][0]), $past(q.gpr[`SLOT_A][7:1])}
        && q.flg[`FLAG_C] == $past(q.gpr[`SLOT_A][0]))
        else $error("accumulator right circular rotate wrong");

    chk_acc_right_thru: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE8]
        commit && q.kind == rot_unit_pkg::K_RRA
        |=> q.gpr[`SLOT_A] == {$past(q.flg[`FLAG_C]), $past(q.gpr[`SLOT_A][7:1])}
        && q.flg[`FLAG_C] == $past(q.gpr[`SLOT_A][0]))
        else $error("accumulator right rotate through carry wrong");

    chk_acc_flag_keep: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE9]
        commit && !rfull |=> !q.flg[`FLAG_H] && !q.flg[`FLAG_N] && $stable(q.flg[`FLAG_S])
        && $stable(q.flg[`FLAG_Z]) && $stable(q.flg[`FLAG_PV]))
        else $error("accumulator rotate flags wrong");

    chk_reg_operand: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE10]
        commit && q.kind == rot_unit_pkg::K_RLC_REG
        |=> q.gpr[$past(q.insn[10:8])] == {$past(q.gpr[q.insn[10:8]][6:0]), $past(q.gpr[q.insn[10:8]][7])}
        && $past(ropnd) == $past(q.gpr[q.insn[10:8]]))
        else $error("register rotate hit the wrong register");

    chk_reg_decode: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE11]
        start && hwdata[7:0] == `PFX_CB && hwdata[15:11] == `RLC_REG_TOP && hwdata[10:8] != 3'h6
        |=> q.kind == rot_unit_pkg::K_RLC_REG)
        else $error("register rotate not decoded");

    chk_prefixed_flags: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE12]
        commit && rfull && q.kind != rot_unit_pkg::K_DEC_X && q.kind != rot_unit_pkg::K_DEC_Y
        |=> q.flg[`FLAG_S] == $past(rres[7]) && q.flg[`FLAG_Z] == ($past(rres) == 8'h00)
        && q.flg[`FLAG_PV] == ~^$past(rres) && !q.flg[`FLAG_H] && !q.flg[`FLAG_N]
        && q.flg[`FLAG_C] == $past(ropnd[7]))
        else $error("prefixed rotate flags wrong");

    chk_ptr_writeback: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE13]
        commit && q.kind == rot_unit_pkg::K_RLC_HL
        |=> q.mem[$past(q.ea[7:0])] == {$past(q.opnd[6:0]), $past(q.opnd[7])})
        else $error("pointer memory rotate not written back");

    chk_idx_address: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE14]
        start && hwdata[7:0] == `PFX_X && hwdata[15:8] == `PFX_CB && hwdata[31:24] == `OP_RLC_MEM
        |=> q.ea == $past(q.ix) + {{8{$past(hwdata[23])}}, $past(hwdata[23:16])})
        else $error("indexed address wrong");

    chk_idx_cycle_count: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE15]
        commit && q.kind == rot_unit_pkg::K_RLC_IDX |-> q.tot == 5'h16 && q.m == 3'h5)
        else $error("indexed rotate not 23 states");

    chk_mem_read_first: assert property (@(posedge hclk) disable iff (!hresetn) // see [RULE16]
        mend && q.st == rot_unit_pkg::ST_MRD
        |=> q.opnd == $past(mem_rd_byte) && q.st == rot_unit_pkg::ST_MWR ##2 commit)
        else $error("memory rotate read and write order wrong");

endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rot_unit_params.svh"
module tb_top;
    typedef struct packed {
        logic [31:0] acc_in;
        logic [11:0] ra;
        logic [31:0] op_in;
        logic [31:0] insn;
        logic [31:0] exp_r;
        logic [31:0] exp_acc;
        logic [2:0] ms;
        logic [4:0] ts;
    } row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [31:0] rd;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    // Operand registers are loaded per row; PTR and INDEX are set up front for the memory rows
    row_t rows [14] = '{
        '{32'h0000d688, `OFF_ACC, 32'h0, 32'h07, 32'h0000c511, 32'h0000c511, 3'h1, 5'h04},
        '{32'h00000176, `OFF_ACC, 32'h0, 32'h17, 32'h000000ed, 32'h000000ed, 3'h1, 5'h04},
        '{32'h00000080, `OFF_ACC, 32'h0, 32'h17, 32'h00000100, 32'h00000100, 3'h1, 5'h04},
        '{32'h00002811, `OFF_ACC, 32'h0, 32'h0f, 32'h00002988, 32'h00002988, 3'h1, 5'h04},
        '{32'h000000e1, `OFF_ACC, 32'h0, 32'h1f, 32'h00000170, 32'h00000170, 3'h1, 5'h04},
        '{32'h00000101, `OFF_ACC, 32'h0, 32'h1f, 32'h00000180, 32'h00000180, 3'h1, 5'h04},
        '{32'h0000fe00, `OFF_GPR, 32'h88000000, 32'hcb, 32'h11000000, 32'h00002d00, 3'h2, 5'h08},
        '{32'h00000100, `OFF_GPR, 32'h12345600, 32'h03cb, 32'h12345600, 32'h00004400, 3'h2, 5'h08},
        '{32'h00000080, `OFF_ACC, 32'h0, 32'h07cb, 32'h00000101, 32'h00000101, 3'h2, 5'h08},
        '{32'h0, 12'h440, 32'h000000c3, 32'h06cb, 32'h00000087, 32'h00008500, 3'h4, 5'h0f},
        '{32'h0, 12'h478, 32'h00000088, 32'h06fecbdd, 32'h00000011, 32'h00000500, 3'h6, 5'h17},
        '{32'h0000d700, `OFF_INDEX, 32'h00002006, 32'h2bfd, 32'hffff2006, 32'h0000d700, 3'h2, 5'h0a},
        '{32'h0000d700, `OFF_INDEX, 32'h76490000, 32'h2bdd, 32'h7649ffff, 32'h0000d700, 3'h2, 5'h0a},
        '{32'h0000ff00, `OFF_PTR, 32'h00001001, 32'h05cb, 32'h00001002, 32'h00002800, 3'h2, 5'h08}
    };
    logic [31:0] tim_insn [2] = '{32'h2bfd, 32'h06fecbdd};
    int tim_n [2] = '{10, 23};

    rotate_unit_and_index_decrement u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(`HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
    );

    always #10 hclk = ~hclk;

    task automatic final_report();
        if (miscompares == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask

    // Entered just after a rising edge; returns in the time step of the data phase's closing edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask

    // Polling is bounded; a stuck busy shows up in the status compare that follows
    task automatic run_insn(input logic [31:0] w);
        int k;
        bus(1'b1, {20'h0, `OFF_INSN}, w, rd);
        k = 0;
        rd = 32'h1;
        while (rd[0] !== 1'b0 && k < 40)
        begin
            bus(1'b0, {20'h0, `OFF_STATUS}, 32'h0, rd);
            k++;
        end
    endtask

    always @(posedge hclk)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            miscompares++;
            final_report();
        end
    end

    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, {20'h0, `OFF_INDEX}, 32'h0, rd);
        check(rd, 32'h0);
        bus(1'b1, {20'h0, `OFF_PTR}, 32'h00000010, rd);
        bus(1'b1, {20'h0, `OFF_INDEX}, 32'h00000020, rd);
        foreach (rows[i])
        begin
            bus(1'b1, {20'h0, `OFF_ACC}, rows[i].acc_in, rd);
            if (rows[i].ra != `OFF_ACC)
                bus(1'b1, {20'h0, rows[i].ra}, rows[i].op_in, rd);
            run_insn(rows[i].insn);
            bus(1'b0, {20'h0, rows[i].ra}, 32'h0, rd);
            check(rd, rows[i].exp_r);
            bus(1'b0, {20'h0, `OFF_ACC}, 32'h0, rd);
            check(rd, rows[i].exp_acc);
            bus(1'b0, {20'h0, `OFF_STATUS}, 32'h0, rd);
            check(rd & 32'h00001f73, {19'h0, rows[i].ts, 1'b0, rows[i].ms, 4'h0});
        end
        // Busy must still show one state before the end and be gone exactly at it
        foreach (tim_insn[i])
            for (int k = 0; k < 2; k++)
            begin
                bus(1'b1, {20'h0, `OFF_INSN}, tim_insn[i], rd);
                repeat (tim_n[i] - 2 + k) @(posedge hclk);
                bus(1'b0, {20'h0, `OFF_STATUS}, 32'h0, rd);
                check({31'h0, rd[0]}, {31'h0, k == 0});
                repeat (30) @(posedge hclk);
            end
        // An unsupported opcode must flag bad and never start
        bus(1'b1, {20'h0, `OFF_INSN}, 32'h000000ff, rd);
        bus(1'b0, {20'h0, `OFF_STATUS}, 32'h0, rd);
        check(rd & 32'h00000003, 32'h00000002);
        bus(1'b1, 32'h00010000, 32'ha5a5a5a5, rd);
        bus(1'b0, 32'h00010000, 32'h0, rd);
        check(rd, 32'h0);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, {20'h0, `OFF_ACC}, 32'h0, rd);
        check(rd, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
